/* File: inc/tx_seq_pkg.sv */
// constants and types shared by the transmitter mode and clock sequencer
package tx_seq_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 40;
   localparam int unsigned LOCK_TIME_NS    = 250000;
   // longest time: round down, at least one cycle
   localparam int unsigned LOCK_CYCLES_RAW = LOCK_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned LOCK_CYCLES     = (LOCK_CYCLES_RAW < 1) ? 1 : LOCK_CYCLES_RAW;
   localparam int unsigned LOCK_CNT_W      = 13;
   localparam int unsigned CLK_DIV         = 8;
   localparam int unsigned DIV_W           = 3;
   localparam logic [DIV_W-1:0] DIV_HIGH_LAST = 3'h3;
   localparam logic [DIV_W-1:0] DIV_RESET     = 3'h0;
   localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_RESET = 13'h0000;

   typedef enum logic [1:0] {
      SEQ_OFF     = 2'b00,
      SEQ_STARTUP = 2'b01,
      SEQ_LOCKING = 2'b11,
      SEQ_READY   = 2'b10
   } seq_state_t;

   typedef enum logic [1:0] {
      MODE_POWER_DOWN = 2'h0,
      MODE_IDLE       = 2'h1,
      MODE_ACTIVE     = 2'h2
   } tx_mode_t;
endpackage : tx_seq_pkg

/* File: rtl/clk_div8.sv */
// divide-by-eight phase counter feeding the clock output driver
`timescale 1ns/100ps
`default_nettype none
module clk_div8
   import tx_seq_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic             ce,
   input  wire logic             run,
   output logic [DIV_W-1:0]      phase,
   output logic                  wrap
);
   logic [DIV_W-1:0] phase_reg;
   logic [DIV_W-1:0] phase_next;

   always_comb begin
      phase_next = run ? phase_reg + 3'h1 : DIV_RESET;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         phase_reg <= DIV_RESET;
      end else if (ce) begin
         phase_reg <= phase_next;
      end
   end

   assign phase = phase_reg;
   // last phase of a period: the next cycle starts a fresh one
   assign wrap  = (phase_reg == 3'h7);
endmodule : clk_div8
`default_nettype wire

/* File: rtl/rf_tx_mode_clock_sequencer.sv */
// mode decoding, power control and clock output sequencing of the transmitter
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RL1: keys low and enable low or floating: everything off, clock output low.
// RL2: enable floating: power-up request is amp key OR freq key.
// RL3: enable driven low with a key high: idle, all blocks off.
// RL4: freq key high, amp key low, enable high/floating: osc and synth on, amp off.
// RL5: clock driver starts once crystal amplitude passes its threshold.
// RL6: clock output stays low until its driver is active.
// RL7: driver starts on a period boundary so first pulse is full.
// RL8: synthesizer locked within 250 us after clock driver start; then ready.
// RL9: amp key high switches amplifier on; host starts FM after 250 us.
// RL10: host keeps device enabled via freq key or enable during AM.
// RL11: freq key low closes crystal switch; high opens it.
// RL12: host should hold freq key high during oscillator start.
// RL13: keys low, enable driven high: osc and synth on, amp off, switch closed.
// RL14: idle with amp key high and enable low: amp key switch high impedance.
// RL15: at 433.92 MHz the clock output is 1.69 MHz for the host.
// RL16: host waits 0.6 ms before taking over the clock output.
// RL17: host waits a further 250 us after take-over before sending.
// RL18: host clock falls back to its RC oscillator when output stops.
// RL19: freq key low gives lower frequency, high gives higher frequency.
// RL20: host ends transmission with all three lines low.
// RL21: clock output is crystal clock divided by eight.
// RL22: host keys the device from two timer modulator outputs.
// RL23: host waits are cycle counters sized for its clock.
module rf_tx_mode_clock_sequencer
   import tx_seq_pkg::*;
#(
   parameter int unsigned LOCK_WAIT_CYCLES = LOCK_CYCLES
)
(
   input  wire logic    ref_clk,
   input  wire logic    srst,
   input  wire logic    ce,
   input  wire logic    amp_key,
   input  wire logic    freq_key,
   input  wire logic    enable_level,
   input  wire logic    enable_driven,
   input  wire logic    crystal_amp_ok,
   output logic         crystal_osc_en,
   output logic         synth_en,
   output logic         pa_on,
   output logic         crystal_switch_hiz,
   output logic         amp_switch_hiz,
   output logic         clock_out,
   output logic         synth_locked,
   output logic [1:0]   mode
);
   typedef struct packed {
      seq_state_t            seq;
      tx_mode_t              mode;
      logic                  osc_en;
      logic                  pa;
      logic                  sw_hiz;
      logic                  amp_hiz;
      logic                  clk;
      logic                  locked;
      logic [LOCK_CNT_W-1:0] lock_cnt;
   } state_t;

   localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_WAIT_CYCLES - 1);

   state_t st_reg;
   state_t st_next;

   logic             power_req;
   logic             idle_req;
   logic [DIV_W-1:0] phase;
   // the divider's wrap flag stays unused: the clock level follows the phase itself
   logic             div_run;

   // floating enable: either key wakes the device
   // driven high: powered even with both keys low
   // driven low: any key only gives idle
   always_comb begin
      if (enable_driven) begin
         power_req = enable_level;                         // [RL13] [RL4]
         idle_req  = !enable_level && (amp_key || freq_key); // [RL3]
      end else begin
         power_req = amp_key || freq_key;                  // [RL2] [RL4]
         idle_req  = 1'b0;
      end
   end

   // divider runs only while the driver is on, so it restarts at phase zero
   assign div_run = (st_reg.seq == SEQ_LOCKING) || (st_reg.seq == SEQ_READY);

   clk_div8 u_div (
      .ref_clk (ref_clk),
      .srst    (srst),
      .ce      (ce),
      .run     (div_run),
      .phase   (phase),
      .wrap    ()
   );

   always_comb begin
      st_next         = st_reg;
      st_next.osc_en  = power_req;
      st_next.pa      = power_req && amp_key;                    // [RL9]
      // switch open with freq key high, open also when unpowered
      st_next.sw_hiz  = freq_key || !power_req;                  // [RL11] [RL1] [RL19]
      st_next.amp_hiz = idle_req && amp_key;                     // [RL14]
      if (power_req) begin
         st_next.mode = MODE_ACTIVE;
      end else if (idle_req) begin
         st_next.mode = MODE_IDLE;                               // [RL3]
      end else begin
         st_next.mode = MODE_POWER_DOWN;                         // [RL1]
      end

      case (st_reg.seq)
         SEQ_OFF: begin
            st_next.lock_cnt = LOCK_CNT_RESET;
            st_next.locked   = 1'b0;
            st_next.clk      = 1'b0;                             // [RL6]
            if (power_req) begin
               st_next.seq = SEQ_STARTUP;
            end
         end
         SEQ_STARTUP: begin
            st_next.clk = 1'b0;                                  // [RL6]
            if (!power_req) begin
               st_next.seq = SEQ_OFF;
            end else if (crystal_amp_ok) begin
               // divider is idle at phase zero, so the first pulse is whole
               st_next.seq = SEQ_LOCKING;                        // [RL5] [RL7]
               st_next.clk = 1'b1;
            end
         end
         SEQ_LOCKING: begin
            // high for phases 0..3, low for 4..7 of each divided period
            st_next.clk = (phase_after(phase) <= DIV_HIGH_LAST); // [RL21] [RL15]
            if (st_reg.lock_cnt == LOCK_LAST) begin
               st_next.seq    = SEQ_READY;                       // [RL8]
               st_next.locked = 1'b1;
            end else begin
               st_next.lock_cnt = st_reg.lock_cnt + 13'h0001;
            end
            if (!power_req) begin
               st_next.seq    = SEQ_OFF;                         // [RL1]
               st_next.clk    = 1'b0;
               st_next.locked = 1'b0;
            end
         end
         SEQ_READY: begin
            st_next.clk = (phase_after(phase) <= DIV_HIGH_LAST); // [RL21]
            if (!power_req) begin
               // stopping the clock lets the host fall back to its own
               st_next.seq    = SEQ_OFF;                         // [RL1]
               st_next.clk    = 1'b0;
               st_next.locked = 1'b0;
            end
         end
         default: begin
            st_next.seq = SEQ_OFF;
            st_next.clk = 1'b0;
         end
      endcase
   end

   // the clock register lags the divider by one cycle; look one phase ahead
   function automatic logic [DIV_W-1:0] phase_after(input logic [DIV_W-1:0] p);
      phase_after = p + 3'h1;
   endfunction : phase_after

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_reg.seq      <= SEQ_OFF;
         st_reg.mode     <= MODE_POWER_DOWN;
         st_reg.osc_en   <= 1'b0;
         st_reg.pa       <= 1'b0;
         st_reg.sw_hiz   <= 1'b1;
         st_reg.amp_hiz  <= 1'b0;
         st_reg.clk      <= 1'b0;
         st_reg.locked   <= 1'b0;
         st_reg.lock_cnt <= LOCK_CNT_RESET;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign crystal_osc_en     = st_reg.osc_en;
   assign synth_en           = st_reg.osc_en;
   assign pa_on              = st_reg.pa;
   assign crystal_switch_hiz = st_reg.sw_hiz;
   assign amp_switch_hiz     = st_reg.amp_hiz;
   assign clock_out          = st_reg.clk;
   assign synth_locked       = st_reg.locked;
   assign mode               = st_reg.mode;
endmodule : rf_tx_mode_clock_sequencer
`default_nettype wire

/* File: verif/crystal_amp_model.sv */
// crystal amplitude model: threshold reached a fixed time after power-up
`timescale 1ns/100ps
`default_nettype none
module crystal_amp_model #(parameter int unsigned RAMP = 5) (
   input  wire logic ref_clk,
   input  wire logic osc_en,
   output logic      amp_ok
);
   int unsigned n = 0;
   initial amp_ok = 1'b0;
   // amplitude collapses as soon as the oscillator is powered off
   always @(posedge ref_clk) begin
      n <= osc_en ? n + 1 : 0;
      amp_ok <= osc_en && n >= RAMP;
   end
endmodule : crystal_amp_model
`default_nettype wire

/* File: verif/tb.sv */
// self-checking testbench for the transmitter sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
   import tx_seq_pkg::*;
   localparam int unsigned LW = 8;
   // host waits counted in reference cycles of 40 ns: 0.6 ms and 250 us
   localparam int unsigned TAKEOVER_CYC = 15000;
   localparam int unsigned SEND_CYC     = 6250;
   logic ref_clk = 1'b0, srst = 1'b1, amp_key = 1'b0, freq_key = 1'b0;
   logic enable_level = 1'b0, enable_driven = 1'b0, amp_ok;
   logic osc_en, synth_en, pa_on, sw_hiz, ask_hiz, clock_out, locked;
   logic [1:0] mode;
   int n_fail = 0, samples_checked = 0;
   always #20 ref_clk = ~ref_clk;
   rf_tx_mode_clock_sequencer #(.LOCK_WAIT_CYCLES(LW)) dut (.ref_clk(ref_clk), .srst(srst),
      .ce(1'b1), .amp_key(amp_key), .freq_key(freq_key), .enable_level(enable_level),
      .enable_driven(enable_driven), .crystal_amp_ok(amp_ok), .crystal_osc_en(osc_en),
      .synth_en(synth_en), .pa_on(pa_on), .crystal_switch_hiz(sw_hiz),
      .amp_switch_hiz(ask_hiz), .clock_out(clock_out), .synth_locked(locked), .mode(mode));
   crystal_amp_model xtal (.ref_clk(ref_clk), .osc_en(osc_en), .amp_ok(amp_ok));
   task automatic chk(string s, logic [7:0] e, logic [7:0] g);
      samples_checked++;
      if (e !== g) begin
         n_fail++;
         $display("mismatch %s exp %0h got %0h", s, e, g);
      end
   endtask : chk
   task automatic tick(int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic drive(logic [3:0] v); // keys stand for the host timer's modulator outputs
      {amp_key, freq_key, enable_level, enable_driven} = v;
   endtask : drive
   task automatic decode_table;
      logic r, idl;
      for (int i = 0; i < 16; i++) begin
         drive(i[3:0]);
         tick(1);
         r = enable_driven ? enable_level : (amp_key | freq_key);
         idl = enable_driven & !enable_level & (amp_key | freq_key);
         chk("osc_en", r, osc_en);
         chk("pa_on", r & amp_key, pa_on);
         chk("sw_hiz", freq_key | !r, sw_hiz);
         chk("ask_hiz", idl & amp_key, ask_hiz);
         chk("mode", idl ? MODE_IDLE : r ? MODE_ACTIVE : MODE_POWER_DOWN, mode);
         if (!r) chk("clock_out", 8'h0, clock_out);
      end
   endtask : decode_table
   task automatic start_up(logic [3:0] v);
      int k;
      drive(v);
      k = 0;
      while (!clock_out && k < 50) begin
         tick(1);
         k++;
      end
      chk("clk_start", 8'h1, clock_out);
      k = 0;
      while (!locked && k < 50) begin
         tick(1);
         k++;
         if (k == 4) chk("clk_div", 8'h0, clock_out);
      end
      chk("lock_wait", 8'(LW), 8'(k));
      tick(TAKEOVER_CYC);
      chk("take_over", 8'h1, locked);
      tick(SEND_CYC);
      drive(v | 4'b1000);
      tick(1);
      chk("pa_key", 8'h1, pa_on);
      freq_key = 1'b0;
      tick(1);
      chk("fsk_low", 8'h0, sw_hiz);
      drive(4'h0);
      tick(1);
      chk("off_clk", 8'h0, clock_out);
      chk("off_lock", 8'h0, locked);
   endtask : start_up
   task automatic stop_test;
      if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   initial begin
      tick(6);
      chk("rst_sw", 8'h1, sw_hiz);
      srst = 1'b0;
      decode_table();
      drive(4'h0);
      tick(2);
      start_up(4'b0100);
      start_up(4'b0111);
      stop_test();
   end
endmodule : tb
`default_nettype wire

/* File: verif/tx_seq_monitor.sv */
// port checker for the transmitter mode and clock sequencer
`timescale 1ns/100ps
`default_nettype none
module tx_seq_monitor #(parameter int unsigned LOCK_WAIT_CYCLES = 8) (
   input wire logic       ref_clk,
   input wire logic       srst,
   input wire logic       amp_key,
   input wire logic       freq_key,
   input wire logic       enable_level,
   input wire logic       enable_driven,
   input wire logic       crystal_amp_ok,
   input wire logic       crystal_osc_en,
   input wire logic       synth_en,
   input wire logic       pa_on,
   input wire logic       crystal_switch_hiz,
   input wire logic       amp_switch_hiz,
   input wire logic       clock_out,
   input wire logic       synth_locked,
   input wire logic [1:0] mode
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   wire req = enable_driven ? enable_level : (amp_key | freq_key);
   wire idl = enable_driven & !enable_level & (amp_key | freq_key);
   // hi_q: length of current high run; on_q: cycles since first clock pulse
   logic [15:0] hi_q;
   logic [15:0] on_q;
   always_ff @(posedge ref_clk) begin
      hi_q <= clock_out ? hi_q + 16'h1 : 16'h0;
      on_q <= (srst || !crystal_osc_en) ? 16'h0 :
              ((clock_out || on_q != 16'h0) ? on_q + 16'h1 : 16'h0);
   end
   osc_decode_a: assert property (1'b1 |=> crystal_osc_en == $past(req))
      else $error("oscillator power wrong");
   synth_pair_a: assert property (synth_en == crystal_osc_en)
      else $error("synth power differs");
   pa_decode_a: assert property (1'b1 |=> pa_on == $past(req & amp_key))
      else $error("amplifier power wrong");
   fsw_decode_a: assert property (1'b1 |=> crystal_switch_hiz == $past(freq_key | !req))
      else $error("crystal switch wrong");
   idle_hiz_a: assert property (1'b1 |=> amp_switch_hiz == $past(idl & amp_key))
      else $error("amp switch wrong");
   mode_decode_a: assert property (1'b1 |=> mode == $past(idl ? 2'h1 : {req, 1'b0}))
      else $error("mode wrong");
   clk_gate_a: assert property (!crystal_osc_en |-> !clock_out)
      else $error("clock out while off");
   clk_start_a: assert property (crystal_osc_en && crystal_amp_ok && on_q == 16'h0
      |=> clock_out)
      else $error("clock driver late");
   clk_run_a: assert property ($fell(clock_out) && crystal_osc_en |-> hi_q == 16'h4)
      else $error("clock high run wrong");
   lock_time_a: assert property (crystal_osc_en |-> synth_locked == (on_q >= LOCK_WAIT_CYCLES))
      else $error("lock timing wrong");
endmodule : tx_seq_monitor
bind rf_tx_mode_clock_sequencer tx_seq_monitor #(.LOCK_WAIT_CYCLES(LOCK_WAIT_CYCLES)) mon (.*);
`default_nettype wire
